// file: dv/fsp_core_model.sv
// Core model: issues register writes and instruction strobes over APB.
// Assumes an APB slave on clk_sys that answers with pready.
`timescale 1ns/1ps
module fsp_core_model (
    input  wire logic        clk_sys,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    logic [31:0] rdata;
    logic        rerr;
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end
    // ------------------------
    // Bus cycles
    // ------------------------
    // The request is left standing so that a transfer can follow at once.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
    endtask : xfer
    // Released write data is inverted so that it never looks held.
    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~pwdata;
        repeat (n) @(posedge clk_sys);
    endtask : idle
    // The strobe follows the command write back to back.
    task automatic cmd(input logic [7:0] c, input logic [1:0] s);
        xfer(1'b1, fsp_pkg::OFS_CTRL, {24'h00_0000, c});
        xfer(1'b1, fsp_pkg::OFS_INSTR, {30'h0000_0000, s});
        idle(1);
    endtask : cmd
endmodule : fsp_core_model

// file: dv/fsp_ctrl_properties.sv
// Port checker for fsp_ctrl, bound into every instance of it.
// Assumes clk_sys is the only clock and rst_b its asynchronous reset.
`timescale 1ns/1ps
module fsp_ctrl_properties #(
    parameter int          BUSY_LEN    = 100,
    parameter logic [15:0] BOOT_VECTOR = 16'h1E00
) (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        global_irq_flag,
    input wire logic        boot_vector_select,
    input wire logic        prog_ready_irq,
    input wire logic        concurrent_section_busy,
    input wire logic        cpu_halt,
    input wire logic [15:0] reset_vector,
    input wire logic [7:0]  lock_bits,
    input wire logic        flash_erase_start,
    input wire logic        flash_write_start,
    input wire logic [9:0]  flash_page,
    input wire logic        flash_word_valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ------------------------
    // Sequences and properties
    // ------------------------
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    sequence s_start;
        flash_erase_start || flash_write_start;
    endsequence
    sequence s_op;
        concurrent_section_busy || cpu_halt;
    endsequence
    a_wait_state: assert property (psel && !penable |=> s_answer)
        else $error("late pready");
    a_pready_one: assert property (pready |=> !pready)
        else $error("long pready");
    a_err_paired: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    a_irq_off: assert property (!global_irq_flag |=> !prog_ready_irq)
        else $error("irq without flag");
    a_app_vector: assert property (
        boot_vector_select [*8] |=> reset_vector == 16'h0000)
        else $error("bad app vector");
    a_boot_vector: assert property (
        !boot_vector_select [*8] |=> ##2 reset_vector == BOOT_VECTOR)
        else $error("bad boot vector");
    a_start_busy: assert property (s_start |-> ##[0:2] s_op)
        else $error("start without busy");
    a_page_latch: assert property (s_start |=> $stable(flash_page) [*8])
        else $error("page moved");
    a_halt_len: assert property ($fell(cpu_halt) |->
        $past(cpu_halt, BUSY_LEN) && !$past(cpu_halt, BUSY_LEN + 1))
        else $error("bad halt length");
    a_lock_mask: assert property ((lock_bits | 8'h3C) == 8'hFF)
        else $error("lock mask");
    a_lock_clear: assert property (
        !$stable(lock_bits) |-> (lock_bits & ~$past(lock_bits)) == 8'h00)
        else $error("lock bit unset");
    a_word_in_op: assert property (flash_word_valid |-> ##[0:1] s_op)
        else $error("stray page word");
endmodule : fsp_ctrl_properties

bind fsp_ctrl fsp_ctrl_properties #(
    .BUSY_LEN(BUSY_LEN), .BOOT_VECTOR(BOOT_VECTOR)
) u_fsp_ctrl_properties (.*);

// file: dv/tb_fsp_ctrl.sv
// Self-checking bench for fsp_ctrl driven through the core model.
// Assumes the package, the model and the checker are compiled first.
`timescale 1ns/1ps
module tb_fsp_ctrl;
    localparam int          BUSY = 40;
    localparam logic [15:0] BOOT = 16'h1E00;
    typedef struct packed {
        logic        ee;
        logic [7:0]  ctrl;
        logic [15:0] z;
        logic [15:0] d;
        logic [3:0]  ewhb;
        logic [7:0]  lock;
    } fsp_row_type;
    // Expected flags: erase start, write start, halt, section busy.
    fsp_row_type rows [10] = '{
        '{1'b0, 8'h03, 16'h0040, 16'h0000, 4'h9, 8'hFF},
        '{1'b0, 8'h01, 16'h0043, 16'h1234, 4'h0, 8'hFF},
        '{1'b0, 8'h05, 16'h0040, 16'h0000, 4'h5, 8'hFF},
        '{1'b0, 8'h07, 16'h0040, 16'h0000, 4'h1, 8'hFF},
        '{1'b0, 8'h11, 16'h0000, 16'h0000, 4'h0, 8'hFF},
        '{1'b0, 8'h09, 16'h0000, 16'h00C3, 4'h0, 8'hC3},
        '{1'b0, 8'h13, 16'h0080, 16'h0000, 4'h0, 8'hC3},
        '{1'b0, 8'h23, 16'h0080, 16'h0000, 4'h9, 8'hC3},
        '{1'b0, 8'h03, 16'hF000, 16'h0000, 4'hB, 8'hC3},
        '{1'b1, 8'h03, 16'h0040, 16'h0000, 4'h1, 8'hC3}};
    logic [7:0]  load_exp [4] = '{8'hA5, 8'hC3, 8'h09, 8'h5A};
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        global_irq_flag, boot_vector_select, eeprom_busy;
    logic        prog_ready_irq, concurrent_section_busy, cpu_halt;
    logic        flash_erase_start, flash_write_start, flash_word_valid;
    logic [7:0]  paddr, fuse_low, fuse_high, lock_bits;
    logic [31:0] pwdata, prdata;
    logic [3:0]  fuse_ext;
    logic [15:0] reset_vector, flash_word, w1;
    logic [9:0]  flash_page;
    logic [4:0]  flash_word_index;
    int          errors, checks, ne, nw, nh, nv;
    fsp_ctrl #(.BUSY_LEN(BUSY), .BOOT_VECTOR(BOOT)) u_fsp_ctrl (
        .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .global_irq_flag, .fuse_low,
        .fuse_high, .fuse_ext, .boot_vector_select, .eeprom_busy,
        .prog_ready_irq, .concurrent_section_busy, .cpu_halt,
        .reset_vector, .lock_bits, .flash_erase_start, .flash_write_start,
        .flash_page, .flash_word_valid, .flash_word, .flash_word_index);
    fsp_core_model u_fsp_core_model (.clk_sys, .pready, .prdata,
        .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    // ------------------------
    // Clock, monitors and helpers
    // ------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        ne <= ne + int'(flash_erase_start === 1'b1);
        nw <= nw + int'(flash_write_start === 1'b1);
        nh <= nh + int'(cpu_halt === 1'b1);
        nv <= nv + int'(flash_word_valid === 1'b1);
        if (flash_word_valid === 1'b1 && flash_word_index === 5'h01) begin
            w1 <= flash_word;
        end
    end
    task automatic check(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : check
    task automatic restart;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : restart
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #400000;
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
    // ------------------------
    // Tests
    // ------------------------
    initial begin
        rst_b = 1'b0;
        global_irq_flag = 1'b0;
        boot_vector_select = 1'b1;
        eeprom_busy = 1'b0;
        fuse_low = 8'h5A;
        fuse_high = 8'hA5;
        fuse_ext = 4'h6;
        restart();
        for (int i = 0; i < 10; i++) begin
            fsp_row_type r;
            int          e0, w0, h0;
            r = rows[i];
            eeprom_busy <= r.ee;
            u_fsp_core_model.idle(3);
            u_fsp_core_model.xfer(1'b1, fsp_pkg::OFS_ZPTR, {16'h0000, r.z});
            u_fsp_core_model.xfer(1'b1, fsp_pkg::OFS_DATA, {16'h0000, r.d});
            e0 = ne;
            w0 = nw;
            h0 = nh;
            u_fsp_core_model.cmd(r.ctrl, 2'b01);
            u_fsp_core_model.xfer(1'b1, fsp_pkg::OFS_ZPTR, 32'h0000_0000);
            u_fsp_core_model.idle(BUSY + 8);
            u_fsp_core_model.xfer(1'b0, fsp_pkg::OFS_CTRL, 32'h0000_0000);
            check(u_fsp_core_model.rdata === {24'h00_0000, 1'b0, r.ewhb[0],
                  6'h00}, "control readback");
            check((ne != e0) == r.ewhb[3], "erase start");
            check((nw != w0) == r.ewhb[2], "write start");
            check((nh != h0) == r.ewhb[1], "halt");
            check(lock_bits === r.lock, "lock bits");
            if (r.ewhb[3] | r.ewhb[2]) begin
                check(flash_page === r.z[15:6], "page");
            end
            $display("row %0d done", i);
        end
        check(w1 === 16'h1234, "buffer word");
        check(nv == 32, "word count");
        u_fsp_core_model.xfer(1'b0, fsp_pkg::OFS_STATUS, 32'h0000_0000);
        check(u_fsp_core_model.rdata === 32'h0000_0002, "status");
        eeprom_busy <= 1'b0;
        u_fsp_core_model.xfer(1'b0, 8'h18, 32'h0000_0000);
        check(u_fsp_core_model.rerr === 1'b1, "unmapped error");
        check(u_fsp_core_model.rdata === 32'h0000_0000, "unmapped data");
        u_fsp_core_model.xfer(1'b1, fsp_pkg::OFS_CTRL, 32'h0000_00A0);
        global_irq_flag <= 1'b1;
        u_fsp_core_model.idle(3);
        check(prog_ready_irq === 1'b1, "irq on");
        u_fsp_core_model.xfer(1'b0, fsp_pkg::OFS_CTRL, 32'h0000_0000);
        check(u_fsp_core_model.rdata === 32'h0000_00C0, "reserved");
        u_fsp_core_model.xfer(1'b1, fsp_pkg::OFS_CTRL, 32'h0000_0081);
        u_fsp_core_model.idle(2);
        check(prog_ready_irq === 1'b0, "irq in window");
        u_fsp_core_model.idle(8);
        check(prog_ready_irq === 1'b1, "irq after window");
        global_irq_flag <= 1'b0;
        $display("irq test done");
        fuse_low <= 8'hA5;
        fuse_high <= 8'h5A;
        fuse_ext <= 4'h9;
        for (int k = 0; k < 4; k++) begin
            u_fsp_core_model.xfer(1'b1, fsp_pkg::OFS_ZPTR, 32'(k));
            u_fsp_core_model.cmd(8'h09, 2'b10);
            u_fsp_core_model.xfer(1'b0, fsp_pkg::OFS_LOADRES, 32'h0000_0000);
            check(u_fsp_core_model.rdata === {24'h00_0000, load_exp[k]},
                  "load result");
        end
        $display("load test done");
        u_fsp_core_model.idle(2);
        check(reset_vector === 16'h0000, "application vector");
        rst_b <= 1'b0;
        boot_vector_select <= 1'b0;
        restart();
        u_fsp_core_model.idle(10);
        check(reset_vector === BOOT, "boot vector");
        check(lock_bits === 8'hFF, "lock reset");
        u_fsp_core_model.xfer(1'b0, fsp_pkg::OFS_CTRL, 32'h0000_0000);
        check(u_fsp_core_model.rdata === 32'h0000_0000, "control reset");
        $display("reset test done");
        summarize();
    end
endmodule : tb_fsp_ctrl

// file: rtl/fsp_ctrl.sv
// Flash self-programming controller: control register, page buffer,
// erase/write sequencing and fuse/lock read-back, reached over APB.
// Assumes fuse pins and the EEPROM busy pin are asynchronous; the
// global interrupt flag comes from the core on the same clock.
//
// Overview of operation
// - Reset vector is 0x0000 with boot select fuse 1, boot start otherwise.
// - Fuses are inputs only; the core has no path to change them.
// - Ready interrupt asserts while irq enable, global flag set, enable clear.
// - Erase/write of concurrent section sets busy flag and blocks that section.
// - Busy flag clears on re-enable after operation, or when buffer fill starts.
// - Control bit 5 reads zero and ignores writes.
// - Re-enable command unblocks the section; refused while erase/write busy.
// - Re-enable written during buffer loading discards loaded data.
// - Lock-set store within four cycles programs lock bits from R0 only.
// - Load within three cycles of lock-set returns lock or fuse byte.
// - Page-write store writes buffer to pointer page; halts on halting section.
// - Page-erase store erases pointer page; halts on halting section.
// - Enable alone: store puts R0 into buffer word, pointer LSB ignored.
// - Enable lasts four cycles, clears after store, stays high during op.
// - Only the five legal low patterns take effect; others ignored.
// - Target page is latched when an operation starts.
// - Low pointer bits pick word, high bits page; loads use Z1:Z0 to pick the byte.
// - Buffer words may be written in any order.
// - Buffer clears after page write, on re-enable, at reset; write-once words.
// - EEPROM write in progress blocks programming and fuse/lock reads.
`timescale 1ns/1ps
module fsp_ctrl #(
    parameter int          PAGE_WORDS  = 32,
    parameter int          BUSY_LEN    = fsp_pkg::BUSY_CYCLES,
    parameter logic [9:0]  HALT_PAGE   = 10'h0_3C0,
    parameter logic [15:0] BOOT_VECTOR = 16'h1_E00
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        global_irq_flag,
    input  wire logic [7:0]  fuse_low,
    input  wire logic [7:0]  fuse_high,
    input  wire logic [3:0]  fuse_ext,
    input  wire logic        boot_vector_select,
    input  wire logic        eeprom_busy,
    output logic             prog_ready_irq,
    output logic             concurrent_section_busy,
    output logic             cpu_halt,
    output logic [15:0]      reset_vector,
    output logic [7:0]       lock_bits,
    output logic             flash_erase_start,
    output logic             flash_write_start,
    output logic [9:0]       flash_page,
    output logic             flash_word_valid,
    output logic [15:0]      flash_word,
    output logic [4:0]       flash_word_index
);

    // ------------------------
    // Sizes and state
    // ------------------------
    localparam int WIDX = $clog2(PAGE_WORDS);
    localparam int PGW  = 15 - WIDX;
    localparam int BCW  = $clog2(BUSY_LEN + 1);
    localparam int PINW = 22;

    typedef struct packed {
        logic [PINW-1:0]               pins_s1;
        logic [PINW-1:0]               pins_s2;
        fsp_pkg::fsp_state_type        state;
        logic [2:0]                    win;
        logic                          irq_en;
        logic                          sec_busy;
        logic [4:0]                    cmd;
        logic [15:0]                   zptr;
        logic [15:0]                   data;
        logic [7:0]                    load_res;
        logic [7:0]                    lock;
        logic                          pready;
        logic [31:0]                   prdata;
        logic                          pslverr;
        logic [PAGE_WORDS-1:0][15:0]   buf_word;
        logic [PAGE_WORDS-1:0]         buf_valid;
        logic [BCW-1:0]                bcnt;
        logic                          op_write;
        logic [PGW-1:0]                page;
        logic                          halt;
        logic                          irq;
        logic [15:0]                   rvec;
        logic [1:0]                    cap;
        logic                          erase_go;
        logic                          write_go;
        logic                          word_valid;
        logic [15:0]                   word;
        logic [WIDX-1:0]               word_idx;
    } fsp_regs_type;

    fsp_regs_type r;
    fsp_regs_type next_r;
    logic         rst_s1;
    logic         rst_sync_b;

    // ------------------------
    // Helpers
    // ------------------------
    function automatic logic fsp_legal(input logic [4:0] c);
        fsp_legal = (c == fsp_pkg::CMD_REEN) || (c == fsp_pkg::CMD_LOCKSET)
                 || (c == fsp_pkg::CMD_PAGE_WRITE_CMD) || (c == fsp_pkg::CMD_PAGE_ERASE_CMD)
                 || (c == fsp_pkg::CMD_FILL);
    endfunction : fsp_legal

    function automatic logic fsp_halting(input logic [PGW-1:0] p);
        fsp_halting = (p >= HALT_PAGE[PGW-1:0]);
    endfunction : fsp_halting

    // ------------------------
    // Reset release
    // ------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1     <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1     <= 1'b1;
            rst_sync_b <= rst_s1;
        end
    end

    // ------------------------
    // Next state
    // ------------------------
    always_comb begin
        logic        acc;
        logic        wr;
        logic [7:0]  fl;
        logic [7:0]  fh;
        logic [3:0]  fe;
        logic        bvs;
        logic        ee;
        logic [7:0]  ctrl_rd;
        logic        store;
        logic        load;
        logic [WIDX-1:0] widx;
        logic [PGW-1:0]  zpage;
        acc     = 1'b0;
        wr      = 1'b0;
        next_r  = r;
        {fl, fh, fe, bvs, ee} = r.pins_s2;
        widx    = r.zptr[WIDX:1];
        zpage   = r.zptr[15:WIDX+1];
        ctrl_rd = {r.irq_en, r.sec_busy, 1'b0, r.cmd};

        // Pin synchronisers; fuses are only ever sampled here.
        next_r.pins_s1 = {fuse_low, fuse_high, fuse_ext,
                          boot_vector_select, eeprom_busy};
        next_r.pins_s2 = r.pins_s1;

        // Reset vector captured once the fuse pin has been synchronised.
        if (r.cap != 2'h3) begin
            next_r.cap  = r.cap + 2'h1;
            next_r.rvec = bvs ? fsp_pkg::APP_RESET_VECTOR
                              : BOOT_VECTOR;
        end

        // APB: one wait state, then the answer from registers.
        acc = psel && penable && !r.pready;
        wr  = psel && penable && r.pready && pwrite;
        next_r.pready  = acc;
        next_r.pslverr = 1'b0;
        next_r.prdata  = 32'h0000_0000;
        if (acc) begin
            if (paddr == fsp_pkg::OFS_CTRL) begin
                next_r.prdata = {24'h00_0000, ctrl_rd};
            end else if (paddr == fsp_pkg::OFS_ZPTR) begin
                next_r.prdata = {16'h0000, r.zptr};
            end else if (paddr == fsp_pkg::OFS_DATA) begin
                next_r.prdata = {16'h0000, r.data};
            end else if (paddr == fsp_pkg::OFS_INSTR) begin
                next_r.prdata = 32'h0000_0000;
            end else if (paddr == fsp_pkg::OFS_LOADRES) begin
                next_r.prdata = {24'h00_0000, r.load_res};
            end else if (paddr == fsp_pkg::OFS_STATUS) begin
                next_r.prdata = {29'h0000_0000,
                                 r.state == fsp_pkg::FSP_BUSY,
                                 ee, r.halt};
            end else begin
                next_r.pslverr = 1'b1;
            end
        end

        store = wr && (paddr == fsp_pkg::OFS_INSTR)
             && pwdata[fsp_pkg::BIT_STORE];
        load  = wr && (paddr == fsp_pkg::OFS_INSTR)
             && pwdata[fsp_pkg::BIT_LOAD];

        // One-cycle flash strobes.
        next_r.erase_go   = 1'b0;
        next_r.write_go   = 1'b0;
        next_r.word_valid = 1'b0;

        if (wr && paddr == fsp_pkg::OFS_ZPTR) begin
            next_r.zptr = pwdata[15:0];
        end
        if (wr && paddr == fsp_pkg::OFS_DATA) begin
            next_r.data = pwdata[15:0];
        end

        case (r.state)
            fsp_pkg::FSP_IDLE: begin
                if (wr && paddr == fsp_pkg::OFS_CTRL) begin
                    next_r.irq_en = pwdata[fsp_pkg::BIT_IRQ_EN];
                    if (fsp_legal(pwdata[4:0]) && !ee) begin
                        next_r.cmd   = pwdata[4:0];
                        next_r.win   = 3'h0;
                        next_r.state = fsp_pkg::FSP_WINDOW;
                        if (pwdata[fsp_pkg::BIT_REEN]) begin
                            next_r.buf_valid = '0;
                        end
                    end
                end
            end
            fsp_pkg::FSP_WINDOW: begin
                next_r.win = r.win + 3'h1;
                if (wr && paddr == fsp_pkg::OFS_CTRL) begin
                    next_r.irq_en = pwdata[fsp_pkg::BIT_IRQ_EN];
                end
                if (load && !ee && r.cmd == fsp_pkg::CMD_LOCKSET
                    && r.win < 3'(fsp_pkg::LOAD_WINDOW)) begin
                    if (r.zptr[0]) begin
                        next_r.load_res = r.zptr[1] ? fh : r.lock;
                    end else begin
                        next_r.load_res = r.zptr[1] ? {4'h0, fe} : fl;
                    end
                    next_r.cmd   = 5'h00;
                    next_r.state = fsp_pkg::FSP_IDLE;
                end else if (store && !ee) begin
                    next_r.cmd   = 5'h00;
                    next_r.state = fsp_pkg::FSP_IDLE;
                    case (r.cmd)
                        fsp_pkg::CMD_FILL: begin
                            next_r.sec_busy = 1'b0;
                            if (!r.buf_valid[widx]) begin
                                next_r.buf_word[widx]  = r.data;
                                next_r.buf_valid[widx] = 1'b1;
                            end
                        end
                        fsp_pkg::CMD_LOCKSET: begin
                            next_r.lock = r.lock & (r.data[7:0]
                                        | ~fsp_pkg::LOCK_MASK);
                        end
                        fsp_pkg::CMD_REEN: begin
                            next_r.sec_busy  = 1'b0;
                            next_r.buf_valid = '0;
                        end
                        fsp_pkg::CMD_PAGE_WRITE_CMD, fsp_pkg::CMD_PAGE_ERASE_CMD: begin
                            next_r.cmd      = r.cmd;
                            next_r.state    = fsp_pkg::FSP_BUSY;
                            next_r.page     = zpage;
                            next_r.bcnt     = '0;
                            next_r.op_write = r.cmd == fsp_pkg::CMD_PAGE_WRITE_CMD;
                            next_r.write_go = r.cmd == fsp_pkg::CMD_PAGE_WRITE_CMD;
                            next_r.erase_go = r.cmd == fsp_pkg::CMD_PAGE_ERASE_CMD;
                            if (fsp_halting(zpage)) begin
                                next_r.halt = 1'b1;
                            end else begin
                                next_r.sec_busy = 1'b1;
                            end
                        end
                        default: begin
                            next_r.cmd = 5'h00;
                        end
                    endcase
                end else if (r.win == 3'(fsp_pkg::STORE_WINDOW - 1)) begin
                    next_r.cmd   = 5'h00;
                    next_r.state = fsp_pkg::FSP_IDLE;
                end
            end
            fsp_pkg::FSP_BUSY: begin
                // Control writes are refused until the operation ends.
                next_r.bcnt = r.bcnt + BCW'(1);
                if (r.op_write && r.bcnt < BCW'(PAGE_WORDS)) begin
                    next_r.word_valid = 1'b1;
                    next_r.word_idx   = r.bcnt[WIDX-1:0];
                    next_r.word       = r.buf_word[r.bcnt[WIDX-1:0]];
                end
                if (r.bcnt == BCW'(BUSY_LEN - 1)) begin
                    next_r.state = fsp_pkg::FSP_IDLE;
                    next_r.cmd   = 5'h00;
                    next_r.halt  = 1'b0;
                    if (r.op_write) begin
                        next_r.buf_valid = '0;
                    end
                end
            end
            default: begin
                next_r.state = fsp_pkg::FSP_IDLE;
            end
        endcase

        // Ready interrupt follows the enable bit.
        next_r.irq = next_r.irq_en && global_irq_flag
                  && !next_r.cmd[fsp_pkg::BIT_ENABLE];
    end

    // ------------------------
    // State register
    // ------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            r          <= '0;
            r.lock     <= fsp_pkg::LOCK_RESET;
            r.state    <= fsp_pkg::FSP_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------
    // Outputs
    // ------------------------
    assign prdata                  = r.prdata;
    assign pready                  = r.pready;
    assign pslverr                 = r.pslverr;
    assign prog_ready_irq          = r.irq;
    assign concurrent_section_busy = r.sec_busy;
    assign cpu_halt                = r.halt;
    assign reset_vector            = r.rvec;
    assign lock_bits               = r.lock;
    assign flash_erase_start       = r.erase_go;
    assign flash_write_start       = r.write_go;
    assign flash_page              = 10'(r.page);
    assign flash_word_valid        = r.word_valid;
    assign flash_word              = r.word;
    assign flash_word_index        = 5'(r.word_idx);

endmodule : fsp_ctrl

// file: rtl/fsp_pkg.sv
// Constants shared by the flash self-programming controller.
// Assumes a 32-bit APB master and a 50 MHz system clock.
package fsp_pkg;

    // ------------------------
    // Register byte offsets
    // ------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ZPTR    = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h08;
    localparam logic [7:0] OFS_INSTR   = 8'h0C;
    localparam logic [7:0] OFS_LOADRES = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;

    // ------------------------
    // Control register fields
    // ------------------------
    localparam int BIT_IRQ_EN  = 7;
    localparam int BIT_SEC_BSY = 6;
    localparam int BIT_REEN    = 4;
    localparam int BIT_LOCKSET = 3;
    localparam int BIT_PAGE_WRITE_CMD   = 2;
    localparam int BIT_PAGE_ERASE_CMD   = 1;
    localparam int BIT_ENABLE  = 0;

    localparam logic [4:0] CMD_REEN    = 5'h11;
    localparam logic [4:0] CMD_LOCKSET = 5'h09;
    localparam logic [4:0] CMD_PAGE_WRITE_CMD   = 5'h05;
    localparam logic [4:0] CMD_PAGE_ERASE_CMD   = 5'h03;
    localparam logic [4:0] CMD_FILL    = 5'h01;

    // Instruction strobe register bits.
    localparam int BIT_STORE = 0;
    localparam int BIT_LOAD  = 1;

    // Status register bits.
    localparam int BIT_ST_HALT = 0;
    localparam int BIT_ST_EE   = 1;
    localparam int BIT_ST_BUSY = 2;

    // Lock byte: bits 5..2 are the only ones a store may program.
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam logic [7:0] LOCK_MASK  = 8'h3C;

    // ------------------------
    // Timing
    // ------------------------
    localparam int CLK_MHZ       = 50;
    localparam int STORE_WINDOW  = 4;
    localparam int LOAD_WINDOW   = 3;
    localparam int BUSY_US       = 2;
    localparam int BUSY_CYCLES   = BUSY_US * CLK_MHZ;
    localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;

    typedef enum logic [1:0] {
        FSP_IDLE   = 2'b00,
        FSP_WINDOW = 2'b01,
        FSP_BUSY   = 2'b11
    } fsp_state_type;

endpackage : fsp_pkg
